// ==== pkg/ctb_pkg.sv ====
// Constants for the transmit buffer request control block.
// Assumes an eight-bit register space and three transmit buffers.
package ctb_pkg;
  // Register offsets
  localparam logic [7:0] PIN_CTRL_OFFSET = 8'h0D;
  localparam logic [7:0] BUF0_OFFSET     = 8'h30;
  localparam logic [7:0] BUF1_OFFSET     = 8'h40;
  localparam logic [7:0] BUF2_OFFSET     = 8'h50;
  // Buffer control field positions
  localparam int ABORTED_BIT   = 6;
  localparam int ARB_LOST_BIT  = 5;
  localparam int TX_ERROR_BIT  = 4;
  localparam int PENDING_BIT   = 3;
  localparam int PRIO_LSB      = 0;
  // Pin control field positions
  localparam int MODE_LSB      = 0;
  localparam int LEVEL_LSB     = 3;
  // Reset values
  localparam logic [7:0] BUF_CTRL_RESET = 8'h00;
  localparam logic [2:0] PIN_MODE_RESET = 3'h0;
  localparam logic       PIN_IDLE_LEVEL = 1'h1;
  // Priority levels
  typedef enum logic [1:0] {
    CTB_PRIO_LOWEST   = 2'b00,
    CTB_PRIO_LOW_MID  = 2'b01,
    CTB_PRIO_HIGH_MID = 2'b10,
    CTB_PRIO_HIGHEST  = 2'b11
  } ctb_prio_type;
endpackage

// ==== rtl/ctb_pin_sync.sv ====
// Request pin synchroniser with falling edge detector.
// Assumes the pin is asynchronous to clock_in and idles high.
`timescale 1ns/1ps
module ctb_pin_sync (
  input  wire logic clock_in,
  input  wire logic rst_b_in,
  input  wire logic pin_n_in,
  output logic      level_out,
  output logic      fall_out
);
  logic meta;
  logic stable;
  logic prev;

  // Two stage sync, then one delay stage for edge detection
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta   <= ctb_pkg::PIN_IDLE_LEVEL;
      stable <= ctb_pkg::PIN_IDLE_LEVEL;
      prev   <= ctb_pkg::PIN_IDLE_LEVEL;
    end else begin
      meta   <= pin_n_in;
      stable <= meta;
      prev   <= stable;
    end
  end

  // High to low seen on synchronised level
  assign level_out = stable;
  assign fall_out  = prev & ~stable;
endmodule

// ==== rtl/ctb_request_ctrl.sv ====
// Transmit buffer request, priority and status control.
// Assumes a simple register port and a protocol engine giving event pulses.
//
// Contract
// - Aborted flag set on abort, clear on success
// - Arbitration-lost flag set on lost arbitration
// - Transmit-error flag set on bus error
// - Pending bit set by host, auto-cleared on send
// - Host clearing pending bit aborts the request
// - Priority 11 highest down to 00 lowest
// - Equal priority: higher buffer index first
// - New request clears all three status flags
// - Pin falling edge sets pending in request mode
// - Pin control writable only in configuration mode
`timescale 1ns/1ps
module ctb_request_ctrl #(
  parameter int NUM_BUF = 3
) (
  input  wire logic               clock_in,
  input  wire logic               rst_b_in,
  input  wire logic [7:0]         reg_addr_in,
  input  wire logic [7:0]         reg_wdata_in,
  input  wire logic               reg_wr_in,
  output logic      [7:0]         reg_rdata_out,
  input  wire logic               config_mode_in,
  input  wire logic [NUM_BUF-1:0] request_pin_n_in,
  input  wire logic [NUM_BUF-1:0] tx_done_in,
  input  wire logic [NUM_BUF-1:0] tx_aborted_in,
  input  wire logic [NUM_BUF-1:0] tx_arb_lost_in,
  input  wire logic [NUM_BUF-1:0] tx_bus_error_in,
  output logic      [NUM_BUF-1:0] pending_out,
  output logic                    sel_valid_out,
  output logic      [1:0]         sel_index_out
);
  // Per buffer state
  logic [NUM_BUF-1:0] pending;
  logic [NUM_BUF-1:0] aborted_flag;
  logic [NUM_BUF-1:0] arbitration_lost_flag;
  logic [NUM_BUF-1:0] transmit_error_flag;
  logic [1:0]         buffer_priority [0:NUM_BUF-1];
  logic [NUM_BUF-1:0] pin_request_mode;

  // Next values
  logic [NUM_BUF-1:0] next_pending;
  logic [NUM_BUF-1:0] next_aborted;
  logic [NUM_BUF-1:0] next_arb_lost;
  logic [NUM_BUF-1:0] next_tx_error;
  logic [1:0]         next_priority [0:NUM_BUF-1];
  logic [NUM_BUF-1:0] next_mode;

  // Decode and pin wires
  wire  [7:0]         buf_offset [0:NUM_BUF-1];
  wire  [NUM_BUF-1:0] buf_hit;
  wire  [NUM_BUF-1:0] buf_wr;
  wire  [NUM_BUF-1:0] set_request;
  wire  [NUM_BUF-1:0] pin_level;
  wire  [NUM_BUF-1:0] pin_fall;
  wire  [NUM_BUF-1:0] pin_request;
  wire  [7:0]         buf_word [0:NUM_BUF-1];
  wire                pin_ctrl_hit;
  wire                pin_ctrl_wr;
  wire  [7:0]         pin_ctrl_word;
  logic [7:0]         next_rdata;

  // Buffer register addresses
  assign buf_offset[0] = ctb_pkg::BUF0_OFFSET;
  assign buf_offset[1] = ctb_pkg::BUF1_OFFSET;
  assign buf_offset[2] = ctb_pkg::BUF2_OFFSET;

  // Pin control decode, writes gated by configuration mode
  assign pin_ctrl_hit = (reg_addr_in == ctb_pkg::PIN_CTRL_OFFSET);
  assign pin_ctrl_wr  = reg_wr_in & pin_ctrl_hit & config_mode_in;
  assign next_mode    = pin_ctrl_wr ? reg_wdata_in[ctb_pkg::MODE_LSB +: NUM_BUF]
                                    : pin_request_mode;

  genvar i;
  generate
    for (i = 0; i < NUM_BUF; i++) begin : g_buf
      // Pin conditioning
      ctb_pin_sync u_pin (
        .clock_in  (clock_in),
        .rst_b_in  (rst_b_in),
        .pin_n_in  (request_pin_n_in[i]),
        .level_out (pin_level[i]),
        .fall_out  (pin_fall[i])
      );

      // Register decode
      assign buf_hit[i]     = (reg_addr_in == buf_offset[i]);
      assign buf_wr[i]      = reg_wr_in & buf_hit[i];
      assign pin_request[i] = pin_fall[i] & pin_request_mode[i];

      // A request that turns pending from zero to one
      assign set_request[i] = ~pending[i] &
                              (pin_request[i] |
                               (buf_wr[i] & reg_wdata_in[ctb_pkg::PENDING_BIT]));

      // Pending: pin or host set, host clear aborts, sent or aborted clears
      assign next_pending[i] = pin_request[i] ? 1'b1 :
                               buf_wr[i] ? reg_wdata_in[ctb_pkg::PENDING_BIT] :
                               pending[i] & ~tx_done_in[i] & ~tx_aborted_in[i];

      // Status flags: event sets win over the clear by a new request
      assign next_aborted[i]  = tx_aborted_in[i] |
                                (aborted_flag[i] & ~set_request[i] & ~tx_done_in[i]);
      assign next_arb_lost[i] = tx_arb_lost_in[i] |
                                (arbitration_lost_flag[i] & ~set_request[i]);
      assign next_tx_error[i] = tx_bus_error_in[i] |
                                (transmit_error_flag[i] & ~set_request[i]);

      // Priority field written by host
      assign next_priority[i] = buf_wr[i] ? reg_wdata_in[ctb_pkg::PRIO_LSB +: 2]
                                          : buffer_priority[i];

      // Read view of buffer control
      assign buf_word[i] = {1'b0, aborted_flag[i], arbitration_lost_flag[i],
                            transmit_error_flag[i], pending[i], 1'b0,
                            buffer_priority[i]};

      // Buffer state registers
      always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          pending[i]               <= ctb_pkg::BUF_CTRL_RESET[ctb_pkg::PENDING_BIT];
          aborted_flag[i]          <= ctb_pkg::BUF_CTRL_RESET[ctb_pkg::ABORTED_BIT];
          arbitration_lost_flag[i] <= ctb_pkg::BUF_CTRL_RESET[ctb_pkg::ARB_LOST_BIT];
          transmit_error_flag[i]   <= ctb_pkg::BUF_CTRL_RESET[ctb_pkg::TX_ERROR_BIT];
          buffer_priority[i]       <= ctb_pkg::BUF_CTRL_RESET[ctb_pkg::PRIO_LSB +: 2];
        end else begin
          pending[i]               <= next_pending[i];
          aborted_flag[i]          <= next_aborted[i];
          arbitration_lost_flag[i] <= next_arb_lost[i];
          transmit_error_flag[i]   <= next_tx_error[i];
          buffer_priority[i]       <= next_priority[i];
        end
      end
    end
  endgenerate

  // Pin level reads zero while the pin is in request mode
  assign pin_ctrl_word = {2'b00, pin_level & ~pin_request_mode, pin_request_mode};

  // Priority pick: larger code wins, ties go to the higher index
  wire       win01   = pending[1] &
                       (~pending[0] | (buffer_priority[1] >= buffer_priority[0]));
  wire [1:0] idx01   = win01 ? 2'd1 : 2'd0;
  wire       any01   = pending[1] | pending[0];
  wire [1:0] prio01  = win01 ? buffer_priority[1] : buffer_priority[0];
  wire       win2    = pending[2] & (~any01 | (buffer_priority[2] >= prio01));
  wire [1:0] next_sel_index = win2 ? 2'd2 : idx01;
  wire       next_sel_valid = pending[2] | any01;

  // Read data mux, unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    if (pin_ctrl_hit) begin
      next_rdata = pin_ctrl_word;
    end else if (buf_hit[0]) begin
      next_rdata = buf_word[0];
    end else if (buf_hit[1]) begin
      next_rdata = buf_word[1];
    end else if (buf_hit[2]) begin
      next_rdata = buf_word[2];
    end
  end

  // Shared registers and outputs
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_request_mode <= ctb_pkg::PIN_MODE_RESET;
      reg_rdata_out    <= 8'h00;
      sel_valid_out    <= 1'b0;
      sel_index_out    <= 2'h0;
    end else begin
      pin_request_mode <= next_mode;
      reg_rdata_out    <= next_rdata;
      sel_valid_out    <= next_sel_valid;
      sel_index_out    <= next_sel_index;
    end
  end

  assign pending_out = pending;
endmodule

// ==== tb/ctb_pin_host_model.sv ====
// Host side model of the three request pins.
// Assumes the bench asks for a low level per pin.
`timescale 1ns/1ps
module ctb_pin_host_model (
  input  wire logic [2:0] pull_low_in,
  output logic      [2:0] pin_n_out
);
  // Released pins rest at pull-up level, skewed off the clock
  assign #7 pin_n_out = ~pull_low_in;
endmodule

// ==== tb/ctb_request_ctrl_properties.sv ====
// Port checker for the transmit buffer request control block.
// Assumes one clock domain; bound onto ctb_request_ctrl.
`timescale 1ns/1ps
module ctb_request_ctrl_properties #(
  parameter int NUM_BUF = 3
) (
  input wire logic               clock_in,
  input wire logic               rst_b_in,
  input wire logic [7:0]         reg_addr_in,
  input wire logic [7:0]         reg_wdata_in,
  input wire logic               reg_wr_in,
  input wire logic [7:0]         reg_rdata_out,
  input wire logic               config_mode_in,
  input wire logic [NUM_BUF-1:0] request_pin_n_in,
  input wire logic [NUM_BUF-1:0] tx_done_in,
  input wire logic [NUM_BUF-1:0] tx_aborted_in,
  input wire logic [NUM_BUF-1:0] tx_arb_lost_in,
  input wire logic [NUM_BUF-1:0] pending_out,
  input wire logic               sel_valid_out
);
  logic [2:0] quiet;
  // Cycles since any request pin was low
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) quiet <= 3'h0;
    else if (!(&request_pin_n_in)) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // Selection, writes, events and read-back
  property p_sel; sel_valid_out == |$past(pending_out); endproperty
  a_sel: assert property (p_sel) else $error("sel valid wrong");
  property p_set; reg_wr_in && reg_addr_in == 8'h50 && reg_wdata_in[3] |=> pending_out[2]; endproperty
  a_set: assert property (p_set) else $error("write set lost");
  property p_clr; reg_wr_in && reg_addr_in == 8'h30 && !reg_wdata_in[3] && quiet > 3'h4 |=> !pending_out[0]; endproperty
  a_clr: assert property (p_clr) else $error("host clear lost");
  property p_done; tx_done_in[2] && !reg_wr_in && quiet > 3'h4 |=> !pending_out[2]; endproperty
  a_done: assert property (p_done) else $error("done kept request");
  property p_abt; tx_aborted_in[1] && !reg_wr_in && quiet > 3'h4 |=> !pending_out[1]; endproperty
  a_abt: assert property (p_abt) else $error("abort kept request");
  property p_arb; tx_arb_lost_in[0] && pending_out[0] && !tx_done_in[0] && !tx_aborted_in[0] && !reg_wr_in |=> pending_out[0]; endproperty
  a_arb: assert property (p_arb) else $error("arb loss dropped request");
  property p_pin; reg_wr_in && reg_addr_in == 8'h0D && !config_mode_in ##1 reg_addr_in == 8'h0D && !reg_wr_in |=> $stable(reg_rdata_out[2:0]); endproperty
  a_pin: assert property (p_pin) else $error("pin control changed");
  property p_rd; reg_addr_in == 8'h30 |=> reg_rdata_out[3] == $past(pending_out[0]) && !reg_rdata_out[7] && !reg_rdata_out[2]; endproperty
  a_rd: assert property (p_rd) else $error("read back wrong");
endmodule
bind ctb_request_ctrl ctb_request_ctrl_properties #(.NUM_BUF(NUM_BUF)) u_chk (.clock_in, .rst_b_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rdata_out, .config_mode_in, .request_pin_n_in,
  .tx_done_in, .tx_aborted_in, .tx_arb_lost_in, .pending_out, .sel_valid_out);

// ==== tb/test_can_tx_buffer_request_control.sv ====
// Bench for the transmit buffer request control block.
// Assumes the pin model and the bound checker compile first.
`timescale 1ns/1ps
module test_can_tx_buffer_request_control;
  logic [7:0] a = 8'h00, d = 8'h00, q;
  logic [2:0] pl = 3'h0, pn, dn = 3'h0, ab = 3'h0, al = 3'h0, be = 3'h0, pe;
  logic       clock_in = 1'b0, rst_b_in = 1'b0, w = 1'b0, cf = 1'b0, sv;
  logic [1:0] si;
  int         n_mismatch = 0, samples_checked = 0;
  // Clock and parts
  always #20 clock_in = ~clock_in;
  ctb_pin_host_model pins (.pull_low_in(pl), .pin_n_out(pn));
  ctb_request_ctrl #(.NUM_BUF(3)) uut (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .reg_addr_in(a), .reg_wdata_in(d), .reg_wr_in(w), .reg_rdata_out(q), .config_mode_in(cf),
    .request_pin_n_in(pn), .tx_done_in(dn), .tx_aborted_in(ab), .tx_arb_lost_in(al),
    .tx_bus_error_in(be), .pending_out(pe), .sel_valid_out(sv), .sel_index_out(si));
  // Bus and compare helpers
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      n_mismatch++;
    end
  endtask
  task automatic wr(input logic [7:0] x, input logic [7:0] y);
    @(posedge clock_in);
    a <= x;
    d <= y;
    w <= 1'b1;
    @(posedge clock_in);
    w <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] x, input logic [7:0] e);
    @(posedge clock_in);
    a <= x;
    repeat (2) @(posedge clock_in);
    #1 chk("rdata", e, q);
  endtask
  task automatic ev(input logic [2:0] x, input logic [2:0] y, input logic [2:0] z);
    @(posedge clock_in);
    dn <= x;
    ab <= y;
    {al, be} <= {z, z};
    @(posedge clock_in);
    {dn, ab, al, be} <= 12'h000;
  endtask
  // Reset values and an unmapped read
  task automatic t_reset;
    rd(8'h30, 8'h00);
    rd(8'h50, 8'h00);
    rd(8'h0D, 8'h38);
    rd(8'h77, 8'h00);
  endtask
  // Priority codes and ties, packed as p0 p1 p2 winner
  task automatic t_prio;
    logic [7:0] t [5] = '{8'hD8, 8'h02, 8'h51, 8'hBE, 8'h25};
    for (int i = 0; i < 5; i++) begin
      wr(8'h30, {6'h02, t[i][7:6]});
      wr(8'h40, {6'h02, t[i][5:4]});
      wr(8'h50, {6'h02, t[i][3:2]});
      repeat (2) @(posedge clock_in);
      #1 chk("sel_index", {5'h00, 1'b1, t[i][1:0]}, {5'h00, sv, si});
    end
  endtask
  // Engine events, host clear, new request, reserved bits
  task automatic t_events;
    ev(3'h4, 3'h0, 3'h0);
    rd(8'h50, 8'h01);
    ev(3'h0, 3'h2, 3'h0);
    rd(8'h40, 8'h42);
    ev(3'h0, 3'h0, 3'h1);
    rd(8'h30, 8'h38);
    wr(8'h30, 8'h00);
    rd(8'h30, 8'h30);
    wr(8'h30, 8'h08);
    rd(8'h30, 8'h08);
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h0B);
  endtask
  // Pin control lock, request mode, input mode
  task automatic t_pins;
    wr(8'h0D, 8'h07);
    rd(8'h0D, 8'h38);
    wr(8'h30, 8'h00);
    wr(8'h40, 8'h00);
    wr(8'h50, 8'h00);
    @(posedge clock_in);
    cf <= 1'b1;
    wr(8'h0D, 8'h07);
    rd(8'h0D, 8'h07);
    @(posedge clock_in);
    pl <= 3'h2;
    repeat (6) @(posedge clock_in);
    #1 chk("pending", 8'h02, {5'h00, pe});
    wr(8'h0D, 8'h00);
    @(posedge clock_in);
    pl <= 3'h4;
    repeat (4) @(posedge clock_in);
    rd(8'h0D, 8'h18);
    chk("pending", 8'h02, {5'h00, pe});
  endtask
  // Verdict
  task automatic summarize;
    $display("Mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence and watchdog
  initial begin
    repeat (20) @(posedge clock_in);
    rst_b_in <= 1'b1;
    t_reset();
    t_prio();
    t_events();
    t_pins();
    summarize();
  end
  initial begin
    repeat (3000) @(posedge clock_in);
    n_mismatch++;
    summarize();
  end
endmodule
